// ### hdl/osw_pkg.sv
// Package: shared constants and types for the operand spec / width block.
// Assumes a single microcycle clock and decoded microinstruction classes.
package osw_pkg;
   localparam logic [1:0] WIDTH_BYTE = 2'h0;
   localparam logic [1:0] WIDTH_WORD = 2'h1;
   localparam logic [1:0] WIDTH_UNUSED = 2'h2;
   localparam logic [1:0] WIDTH_LONG = 2'h3;
   localparam logic [7:0] ADDR_OPSPEC = 8'h7C;
   localparam logic [7:0] ADDR_WIDTH_LD = 8'h7D;
   localparam logic [7:0] ADDR_WIDTH_RW = 8'h7E;
   localparam logic [2:0] AUX_FN2_BUS_REQ = 3'h4;
   localparam int FIELD_LO = 5;
   localparam logic [1:0] FLAG_LONG_HOLD = 2'h0;
   localparam logic [1:0] FLAG_LONG_SET = 2'h1;
   localparam logic [1:0] MEMW_USE_SIZE = 2'h2;
   localparam logic [1:0] MWCTL_HOLD = 2'h3;
   localparam logic [1:0] MWCTL_LONG = 2'h2;
   localparam logic [7:0] OPSPEC_RESET = 8'h00;
   localparam logic [1:0] WIDTH_RESET = 2'h3;
   localparam logic [1:0] MEMW_RESET = 2'h3;
   localparam logic [1:0] SEL_HOLD = 2'h0;
   localparam logic [1:0] SEL_PREFETCH = 2'h1;

   typedef enum logic [2:0]
   {
      OSW_UOP_NONE = 3'b000,
      OSW_UOP_ALU = 3'b001,
      OSW_UOP_MOVE = 3'b010,
      OSW_UOP_WIDE = 3'b011,
      OSW_UOP_MEMREQ = 3'b100,
      OSW_UOP_DISPATCH = 3'b101,
      OSW_UOP_AUX = 3'b110
   } osw_uop_e;

   typedef struct packed
   {
      osw_uop_e uop;
      logic [7:0] d_addr;
      logic xfer_ok;
      logic [2:0] aux_fn2;
      logic [31:0] word;
   } osw_uinst_s;
endpackage

// ### hdl/osw_read_align.sv
// Read align: sizes and sign-extends memory read data by a width code.
// Assumes the width code is one of byte, word or longword.
`timescale 1ns/10ps
module osw_read_align
   import osw_pkg::*;
(
   input wire logic [31:0] data,
   input wire logic [1:0] width,
   output logic [31:0] aligned
);
   always_comb
   begin
      case (width)
         WIDTH_BYTE:
            aligned = {{24{data[7]}}, data[7:0]};
         WIDTH_WORD:
            aligned = {{16{data[15]}}, data[15:0]};
         default:
            aligned = data;
      endcase
   end
endmodule

// ### hdl/osw_top.sv
// Top: operand specifier register and data width control.
// Assumes microinstruction inputs and buses come from the same clock.
// Assumes read data stands on its bus during the move that takes it.
`timescale 1ns/10ps
module osw_top
   import osw_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire osw_uinst_s UINST,
   input wire logic [1:0] OPSPEC_LOAD_SELECT,
   input wire logic [7:0] PREFETCH_BUS,
   input wire logic [31:0] Y_BUS,
   input wire logic [1:0] OPCODE_WIDTH_CLASS,
   input wire logic CLASS_DECODE_PHASE,
   input wire logic LEGACY_MODE,
   input wire logic [31:0] MEMCTL_READ_DATA,
   output logic [31:0] D_BUS,
   output logic D_BUS_EN,
   output logic [3:0] BUS_REQ,
   output logic [1:0] MEMCTL_BUS_WIDTH,
   output logic [1:0] ALU_FLAGS_WIDTH,
   output logic [2:0] LS_WRITE_EN,
   output logic [7:0] OPERAND_SPEC,
   output logic [1:0] OP_WIDTH,
   output logic [1:0] MEM_READ_WIDTH
);
   logic [7:0] operand_spec_reg_q;
   logic [1:0] op_width_q;
   logic [1:0] mem_read_width_reg_q;
   logic read_pending_q;
   logic [1:0] xfer_width;
   logic width_valid;
   logic [1:0] mem_width_load_ctl;
   logic [31:0] aligned_read;
   logic is_xfer;
   logic y_to_opspec_load;
   logic width_load_y;
   logic [31:0] d_bus_d;
   logic d_en_d;
   logic [2:0] ls_en_d;
   logic [1:0] flag_ctl_field;
   logic is_memreq;
   logic is_dispatch;
   logic prefetch_load;
   logic class_load;
   logic aux_bus_req;
   logic d_sel_spec;
   logic d_sel_stat;
   logic d_sel_read;

   // Same bits serve as flag field and memory width field
   assign flag_ctl_field = UINST.word[FIELD_LO+1:FIELD_LO];
   assign is_xfer = (UINST.uop == OSW_UOP_ALU) || (UINST.uop == OSW_UOP_MOVE);
   assign is_memreq = (UINST.uop == OSW_UOP_MEMREQ);
   assign is_dispatch = (UINST.uop == OSW_UOP_DISPATCH);
   assign y_to_opspec_load = is_xfer && UINST.xfer_ok &&
                             (UINST.d_addr == ADDR_OPSPEC);
   assign width_load_y = is_xfer && ((UINST.d_addr == ADDR_WIDTH_LD) ||
                                     (UINST.d_addr == ADDR_WIDTH_RW));
   assign prefetch_load = is_dispatch &&
                          (OPSPEC_LOAD_SELECT == SEL_PREFETCH);
   assign class_load = is_dispatch && CLASS_DECODE_PHASE;
   assign aux_bus_req = (UINST.uop == OSW_UOP_AUX) &&
                        (UINST.aux_fn2 == AUX_FN2_BUS_REQ);

   // D bus sources; spec wins, then status, then read data
   assign d_sel_spec = y_to_opspec_load;
   assign d_sel_stat = is_xfer && (UINST.d_addr == ADDR_WIDTH_RW);
   // Read data waits for the first move after any request
   assign d_sel_read = (UINST.uop == OSW_UOP_MOVE) && read_pending_q;

   osw_width_decode u_width
   (
      .uop(UINST.uop),
      .field(flag_ctl_field),
      .op_width(op_width_q),
      .legacy(LEGACY_MODE),
      .width(xfer_width),
      .valid(width_valid)
   );

   osw_read_align u_align
   (
      .data(MEMCTL_READ_DATA),
      .width(mem_read_width_reg_q),
      .aligned(aligned_read)
   );

   always_comb
   begin
      if (is_memreq)
      begin
         case (xfer_width)
            WIDTH_BYTE:
               mem_width_load_ctl = 2'h0;
            WIDTH_WORD:
               mem_width_load_ctl = 2'h1;
            default:
               mem_width_load_ctl = MWCTL_LONG;
         endcase
      end
      else
         mem_width_load_ctl = MWCTL_HOLD;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         operand_spec_reg_q <= OPSPEC_RESET;
      else if (y_to_opspec_load)
         operand_spec_reg_q <= Y_BUS[7:0];
      else if (prefetch_load)
         operand_spec_reg_q <= PREFETCH_BUS;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         op_width_q <= WIDTH_RESET;
      // reload from Y
      // Code 10 is never stored, so it folds to longword
      else if (width_load_y)
         op_width_q <= (Y_BUS[1:0] == WIDTH_UNUSED) ? WIDTH_LONG : Y_BUS[1:0];
      // class decode load
      // Y load wins when both fall in one cycle
      else if (class_load)
         op_width_q <= (OPCODE_WIDTH_CLASS == WIDTH_UNUSED) ?
                       WIDTH_LONG : OPCODE_WIDTH_CLASS;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         mem_read_width_reg_q <= MEMW_RESET;
      else
      begin
         case (mem_width_load_ctl)
            2'h0:
               mem_read_width_reg_q <= WIDTH_BYTE;
            2'h1:
               mem_read_width_reg_q <= WIDTH_WORD;
            MWCTL_LONG:
               mem_read_width_reg_q <= WIDTH_LONG;
            default:
               mem_read_width_reg_q <= mem_read_width_reg_q;
         endcase
      end
   end

   // Read pending until the next move
   // Reads and writes are not told apart here
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         read_pending_q <= 1'b0;
      else if (is_memreq)
         read_pending_q <= 1'b1;
      else if (UINST.uop == OSW_UOP_MOVE)
         read_pending_q <= 1'b0;
   end

   // D bus source select
   always_comb
   begin
      d_bus_d = 32'h0000_0000;
      d_en_d = 1'b0;
      if (d_sel_spec)
      begin
         d_bus_d = {{24{operand_spec_reg_q[7]}}, operand_spec_reg_q};
         d_en_d = 1'b1;
      end
      else if (d_sel_stat)
      begin
         d_bus_d[1:0] = op_width_q;
         d_bus_d[7:6] = mem_read_width_reg_q;
         d_en_d = 1'b1;
      end
      else if (d_sel_read)
      begin
         d_bus_d = aligned_read;
         d_en_d = 1'b1;
      end
   end

   always_comb
   begin
      ls_en_d = 3'h0;
      if (is_xfer && width_valid)
      begin
         case (xfer_width)
            WIDTH_BYTE:
               ls_en_d = 3'h1;
            WIDTH_WORD:
               ls_en_d = 3'h3;
            default:
               ls_en_d = 3'h7;
         endcase
      end
   end

   // D bus data, zero when no source drives
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         D_BUS <= 32'h0000_0000;
      else
         D_BUS <= d_bus_d;
   end

   // D bus enable
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         D_BUS_EN <= 1'b0;
      else
         D_BUS_EN <= d_en_d;
   end

   // Store write enables
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         LS_WRITE_EN <= 3'h0;
      else
         LS_WRITE_EN <= ls_en_d;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         BUS_REQ <= 4'h0;
      else if (aux_bus_req)
         BUS_REQ <= operand_spec_reg_q[3:0];
      else
         BUS_REQ <= 4'h0;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         MEMCTL_BUS_WIDTH <= WIDTH_LONG;
      else
         MEMCTL_BUS_WIDTH <= xfer_width;
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         ALU_FLAGS_WIDTH <= WIDTH_LONG;
      else
         ALU_FLAGS_WIDTH <= xfer_width;
   end

   // Operand spec mirror, one cycle behind
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         OPERAND_SPEC <= OPSPEC_RESET;
      else
         OPERAND_SPEC <= operand_spec_reg_q;
   end

   // Width register mirror
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         OP_WIDTH <= WIDTH_RESET;
      else
         OP_WIDTH <= op_width_q;
   end

   // Read width mirror
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         MEM_READ_WIDTH <= MEMW_RESET;
      else
         MEM_READ_WIDTH <= mem_read_width_reg_q;
   end
endmodule

// ### hdl/osw_width_decode.sv
// Width decode: turns the flag or width field into a transfer width code.
// Assumes the decoded microinstruction class is stable within the cycle.
`timescale 1ns/10ps
module osw_width_decode
   import osw_pkg::*;
(
   input wire osw_uop_e uop,
   input wire logic [1:0] field,
   input wire logic [1:0] op_width,
   input wire logic legacy,
   output logic [1:0] width,
   output logic valid
);
   logic [1:0] raw;
   always_comb
   begin
      raw = WIDTH_LONG;
      valid = 1'b0;
      case (uop)
         OSW_UOP_ALU, OSW_UOP_MOVE, OSW_UOP_WIDE:
         begin
            valid = 1'b1;
            if (field == FLAG_LONG_HOLD || field == FLAG_LONG_SET)
               raw = WIDTH_LONG;
            else
               raw = op_width;
         end
         OSW_UOP_MEMREQ:
         begin
            valid = 1'b1;
            if (field == MEMW_USE_SIZE)
               raw = op_width;
            else
               raw = field;
         end
         default:
            raw = WIDTH_LONG;
      endcase
      if (raw == WIDTH_UNUSED)
         raw = WIDTH_LONG;
      if (legacy && raw == WIDTH_LONG)
         width = WIDTH_WORD;
      else
         width = raw;
   end
endmodule

// ### sim/osw_memctl.sv
// Memory partner: answers one read in the cycle after a request.
// Assumes the width code on its port sizes the transfer.
`timescale 1ns/10ps
module osw_memctl
   import osw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire osw_uinst_s uinst,
   input wire logic [1:0] width,
   input wire logic [31:0] fill,
   output logic [31:0] rdata
);
   logic pend_q;
   logic [31:0] data_q, junk_q, keep;
   assign keep = width == WIDTH_BYTE ? 32'hFF :
      width == WIDTH_WORD ? 32'hFFFF : '1;
   assign rdata = pend_q ? data_q & keep | junk_q & ~keep : junk_q;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         pend_q <= 1'h0;
         junk_q <= 32'h5A5A_A5A5;
      end
      else
      begin
         pend_q <= uinst.uop == OSW_UOP_MEMREQ;
         junk_q <= ~junk_q;
         if (uinst.uop == OSW_UOP_MEMREQ)
            data_q <= fill;
      end
endmodule

// ### sim/osw_properties.sv
// Checker: port timing of the operand spec and width block.
// Assumes a bind to osw_top on its single clock.
`timescale 1ns/10ps
module osw_properties
   import osw_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire osw_uinst_s UINST,
   input wire logic [31:0] Y_BUS,
   input wire logic LEGACY_MODE,
   input wire logic [31:0] D_BUS,
   input wire logic D_BUS_EN,
   input wire logic [3:0] BUS_REQ,
   input wire logic [1:0] MEMCTL_BUS_WIDTH,
   input wire logic [7:0] OPERAND_SPEC,
   input wire logic [1:0] OP_WIDTH,
   input wire logic [1:0] MEM_READ_WIDTH
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   logic rw, dc;
   assign rw = UINST.uop inside {OSW_UOP_ALU, OSW_UOP_MOVE};
   assign dc = rw || UINST.uop == OSW_UOP_WIDE;
   sequence s_spec;
      rw && UINST.xfer_ok && UINST.d_addr == ADDR_OPSPEC;
   endsequence
   sequence s_memreq;
      UINST.uop == OSW_UOP_MEMREQ ##1 1'h1;
   endsequence
   a_spec_load:
      assert property (s_spec |-> ##2 OPERAND_SPEC == $past(Y_BUS[7:0], 2))
      else $error("spec load wrong");
   a_spec_sext:
      assert property (s_spec |=> D_BUS_EN &&
         D_BUS == {{24{OPERAND_SPEC[7]}}, OPERAND_SPEC})
      else $error("spec read wrong");
   a_req_lines:
      assert property (UINST.uop == OSW_UOP_AUX &&
         UINST.aux_fn2 == AUX_FN2_BUS_REQ |=> BUS_REQ == OPERAND_SPEC[3:0])
      else $error("request lines wrong");
   a_stat_read:
      assert property (rw && UINST.xfer_ok && UINST.d_addr == ADDR_WIDTH_RW
         |=> D_BUS_EN && D_BUS[1:0] == OP_WIDTH && D_BUS[7:6] == MEM_READ_WIDTH)
      else $error("status read wrong");
   a_flag_long:
      assert property (dc && !UINST.word[6] |=> MEMCTL_BUS_WIDTH ==
         ($past(LEGACY_MODE) ? WIDTH_WORD : WIDTH_LONG))
      else $error("long code wrong");
   a_flag_size:
      assert property (dc && UINST.word[6] && !LEGACY_MODE
         |=> MEMCTL_BUS_WIDTH == OP_WIDTH)
      else $error("size code wrong");
   a_mem_field:
      assert property (UINST.uop == OSW_UOP_MEMREQ && !LEGACY_MODE &&
         UINST.word[6:5] != MEMW_USE_SIZE
         |=> MEMCTL_BUS_WIDTH == $past(UINST.word[6:5]))
      else $error("memory width wrong");
   a_rdw_load:
      assert property (s_memreq |=> MEM_READ_WIDTH == $past(MEMCTL_BUS_WIDTH))
      else $error("read width load wrong");
   a_rdw_hold:
      assert property (UINST.uop != OSW_UOP_MEMREQ |-> ##2
         $stable(MEM_READ_WIDTH))
      else $error("read width changed");
endmodule
bind osw_top osw_properties u_props (.CLK, .RST_N, .UINST, .Y_BUS,
   .LEGACY_MODE, .D_BUS, .D_BUS_EN, .BUS_REQ, .MEMCTL_BUS_WIDTH,
   .OPERAND_SPEC, .OP_WIDTH, .MEM_READ_WIDTH);

// ### sim/osw_top_tb.sv
// Testbench: random microinstructions checked against a reference model.
// Assumes osw_top, the memory partner and the bound checker.
`timescale 1ns/10ps
module osw_top_tb
   import osw_pkg::*;
;
   logic CLK = '0, RST_N = '0, ph = '0, lg = '0, en;
   osw_uinst_s u = '0;
   logic [1:0] sel = '0, cl = '0, mcw, afw, ow, mrw;
   logic [7:0] pf = '0, spc;
   logic [31:0] y = '0, fill = '0, rd, d;
   logic [3:0] br;
   logic [2:0] ls;
   int failures, n_compared, seed, spec, wid, mw, pend, r;
   int rdq[$];
   osw_top uut (.CLK(CLK), .RST_N(RST_N), .UINST(u),
      .OPSPEC_LOAD_SELECT(sel), .PREFETCH_BUS(pf), .Y_BUS(y),
      .OPCODE_WIDTH_CLASS(cl), .CLASS_DECODE_PHASE(ph), .LEGACY_MODE(lg),
      .MEMCTL_READ_DATA(rd), .D_BUS(d), .D_BUS_EN(en), .BUS_REQ(br),
      .MEMCTL_BUS_WIDTH(mcw), .ALU_FLAGS_WIDTH(afw), .LS_WRITE_EN(ls),
      .OPERAND_SPEC(spc), .OP_WIDTH(ow), .MEM_READ_WIDTH(mrw));
   osw_memctl part (.clk(CLK), .rst_n(RST_N), .uinst(u), .width(mcw),
      .fill(fill), .rdata(rd));
   always #2 CLK = ~CLK;
   function automatic logic [31:0] sx(logic [31:0] v, int w);
      return w == 0 ? {{24{v[7]}}, v[7:0]} :
         w == 1 ? {{16{v[15]}}, v[15:0]} : v;
   endfunction
   function automatic int fx(logic [1:0] v);
      return v == 2'h2 ? 3 : int'(v);
   endfunction
   task chk(logic [31:0] g, logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task conclude;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task rst;
      u = '0;
      RST_N = '0;
      repeat (6) @(posedge CLK);
      #1;
      chk(32'({spc, ow, mrw}), 32'({OPSPEC_RESET, WIDTH_RESET, MEMW_RESET}));
      chk(32'({en, br, ls, mcw, afw}), 32'({WIDTH_LONG, WIDTH_LONG}));
      chk(d, 32'h0000_0000);
      RST_N = '1;
      spec = 0;
      wid = 3;
      mw = 3;
      pend = 0;
      rdq.delete();
   endtask
   task step;
      int o, w, e;
      o = int'(u.uop);
      w = 3;
      if (o inside {1, 2, 3})
         w = u.word[6] ? wid : 3;
      if (o == 4)
         w = u.word[6:5] == 2'h2 ? wid : int'(u.word[6:5]);
      if (lg && w == 3)
         w = 1;
      e = !(o inside {1, 2}) ? 0 :
         u.d_addr == ADDR_OPSPEC && u.xfer_ok ? 1 :
         u.d_addr == ADDR_WIDTH_RW ? 2 : (o == 2 && pend != 0) ? 3 : 0;
      @(posedge CLK);
      #1;
      if (o inside {1, 2, 3, 4})
      begin
         chk(32'(mcw), w);
         chk(32'(afw), w);
      end
      if (!(o inside {1, 2}) || u.d_addr < 8'h78)
         chk(32'(ls), o > 2 || o == 0 ? 0 : w == 0 ? 1 : w == 1 ? 3 : 7);
      chk(32'(br), o == 6 && u.aux_fn2 == 3'h4 ? spec % 16 : 0);
      chk(32'({spc, ow, mrw}), 32'({8'(spec), 2'(wid), 2'(mw)}));
      chk(32'(en), e > 0);
      if (e == 1)
         chk(d, sx(spec, 0));
      if (e == 2)
         chk(32'({d[7:6], d[1:0]}), 32'({2'(mw), 2'(wid)}));
      if (e == 3)
         chk(d, sx(rdq.pop_front(), mw));
      if (e == 1)
         spec = y[7:0];
      else if (o == 5 && sel == 2'h1)
         spec = pf;
      if (o inside {1, 2} && u.d_addr inside {ADDR_WIDTH_LD, ADDR_WIDTH_RW})
         wid = fx(y[1:0]);
      else if (o == 5 && ph)
         wid = fx(cl);
      if (o == 4)
         mw = w;
      if (o == 4)
         rdq.push_back(int'(fill));
      pend = o == 4;
      r = {$random(seed)} % 4;
      u.uop = osw_uop_e'(pend != 0 ? 2 : {$random(seed)} % 7);
      u.d_addr = pend != 0 || r == 3 ? 8'h10 : 8'h7C + 8'(r);
      u.xfer_ok = 2'($random(seed)) != 2'h0;
      u.aux_fn2 = 3'($random(seed));
      u.word = $random(seed);
      y = $random(seed);
      fill = $random(seed);
      pf = 8'($random(seed));
      sel = 2'($random(seed));
      cl = 2'($random(seed));
      ph = 1'($random(seed));
      lg = 2'($random(seed)) == 2'h0;
   endtask
   initial
   begin
      seed = 98461;
      rst;
      repeat (800) step;
      rst;
      repeat (700) step;
      conclude;
   end
   initial
   begin
      #20000;
      failures++;
      conclude;
   end
endmodule
